// ==== core_model.sv ====
// far-side model of the endpoint core: request source and completion sink
`timescale 1ns/1ps
module core_model (
    // clock
    input wire logic clk,
    // request stream
    output logic [pio_pkg::DATA_W-1:0] cq_tdata,
    output logic cq_tvalid,
    output logic cq_tlast,
    input wire logic cq_tready,
    // completion stream control
    output logic cc_tready,
    input wire logic hold_off,
    input wire logic rnd,
    // status
    output int hangs
);
    initial begin
        cq_tdata = '0;
        cq_tvalid = 1'b0;
        cq_tlast = 1'b0;
        cc_tready = 1'b0;
        hangs = 0;
    end
    // random stalls, or a full stop while the bench fills the fifo
    always @(negedge clk) begin
        cc_tready <= !hold_off && rnd;
    end
    task automatic send(input logic [pio_pkg::PKT_W-1:0] p, input int n);
        int w;
        for (int k = 0; k < n; k++) begin
            @(negedge clk);
            cq_tdata <= p[64*k+:64];
            cq_tvalid <= 1'b1;
            cq_tlast <= (k == n - 1);
            w = 0;
            do begin
                @(posedge clk);
                w++;
            end while (cq_tready !== 1'b1 && w < 300);
            if (cq_tready !== 1'b1) hangs++;
        end
        @(negedge clk);
        cq_tvalid <= 1'b0;
        cq_tlast <= 1'b0;
        // released data lines must not keep showing the last beat
        cq_tdata <= ~p[64*(n-1)+:64];
    endtask
endmodule

// ==== pio_completer_target.sv ====
// single-dword completer target behind the endpoint request/completion streams
`timescale 1ns/1ps

module pio_completer_target #(
    parameter logic io_region_en = 1'b0,
    parameter logic [2:0] io_region_sel = pio_pkg::SEL_IO_DEFAULT
) (
    // clock, reset, enable
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    // completer request stream
    input wire logic [pio_pkg::DATA_W-1:0] cq_tdata,
    input wire logic cq_tvalid,
    input wire logic cq_tlast,
    output logic completer_request_ready,
    // completion stream
    output logic [pio_pkg::DATA_W-1:0] cc_tdata,
    output logic [pio_pkg::KEEP_W-1:0] cc_tkeep,
    output logic cc_tlast,
    output logic cc_tvalid,
    input wire logic cc_tready,
    // trigger pulses toward the core
    output logic mem_read_start,
    output logic intx_request,
    output logic msi_request,
    output logic msix_request
);
    // ------------------------------------------------------------
    // types and helpers
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_RX,
        ST_EXEC,
        ST_RDWAIT,
        ST_CPL
    } state_t;

    // {hit, index} for a selector value
    function automatic logic [2:0] region_of(input logic [2:0] sel);
        if (sel == pio_pkg::SEL_MEM32) begin
            region_of = {1'b1, pio_pkg::IDX_MEM32};
        end else if (sel == pio_pkg::SEL_MEM64) begin
            region_of = {1'b1, pio_pkg::IDX_MEM64};
        end else if (sel == pio_pkg::SEL_EROM) begin
            region_of = {1'b1, pio_pkg::IDX_EROM};
        end else if (io_region_en && sel == io_region_sel) begin
            region_of = {1'b1, pio_pkg::IDX_IO};
        end else begin
            region_of = 3'h0;
        end
    endfunction

    // beats needed to carry a number of dwords
    function automatic logic [pio_pkg::BEAT_CNT_W-1:0] beats_for(input logic [2:0] ndw);
        beats_for = pio_pkg::BEAT_CNT_W'((32 * int'(ndw) + pio_pkg::DATA_W - 1) / pio_pkg::DATA_W);
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    state_t state_reg;
    logic ready_reg;
    logic [pio_pkg::PKT_W-1:0] pkt_reg;
    logic [pio_pkg::BEAT_CNT_W-1:0] beat_cnt_reg;
    logic [pio_pkg::CPL_BUF_W-1:0] cpl_reg;
    logic [2:0] cpl_dw_reg;
    logic [pio_pkg::BEAT_CNT_W-1:0] cpl_beat_reg;
    logic mrd_reg;
    logic intx_reg;
    logic msi_reg;
    logic msix_reg;
    logic [pio_pkg::DATA_W-1:0] cc_data_reg;
    logic [pio_pkg::KEEP_W-1:0] cc_keep_reg;
    logic cc_last_reg;
    logic cc_valid_reg;

    // ------------------------------------------------------------
    // descriptor decode
    // ------------------------------------------------------------
    logic [10:0] dw_count;
    logic [3:0] req_type;
    logic [2:0] region_hit;
    logic [1:0] region_idx;
    logic region_ok;
    logic single_dw;
    logic is_write;
    logic is_read;
    logic is_io_wr;
    logic [pio_pkg::WORD_ADDR_W-1:0] word_addr;
    logic [10:0] byte_addr;
    logic [31:0] payload;

    assign dw_count = pkt_reg[pio_pkg::F_DWCNT_LO +: 11];
    assign req_type = pkt_reg[pio_pkg::F_REQTYPE_LO +: 4];
    assign region_hit = region_of(pkt_reg[pio_pkg::F_SEL_LO +: 3]);
    assign region_idx = region_hit[1:0];
    assign region_ok = region_hit[2];
    assign single_dw = (dw_count == 11'h001);
    assign is_write = (req_type == pio_pkg::REQ_MEM_WR) || (req_type == pio_pkg::REQ_IO_WR);
    assign is_read = (req_type == pio_pkg::REQ_MEM_RD) || (req_type == pio_pkg::REQ_IO_RD);
    assign is_io_wr = (req_type == pio_pkg::REQ_IO_WR);
    // upper address bits are ignored, so large windows alias the 2 KB ram
    assign word_addr = pkt_reg[pio_pkg::F_ADDR_LO +: pio_pkg::WORD_ADDR_W];
    assign byte_addr = {word_addr, 2'b00};
    assign payload = pkt_reg[pio_pkg::F_PAYLOAD_LO +: 32];

    logic accept_ok;
    assign accept_ok = region_ok && single_dw && (is_write || is_read);

    // ------------------------------------------------------------
    // region rams
    // ------------------------------------------------------------
    logic [31:0] rd_word [pio_pkg::REGION_COUNT];
    logic ram_we;
    logic ram_re;

    assign ram_we = (state_reg == ST_EXEC) && accept_ok && is_write;
    assign ram_re = (state_reg == ST_EXEC) && accept_ok && is_read;

    for (genvar r = 0; r < pio_pkg::REGION_COUNT; r++) begin : g_region
        region_ram #(
            .ADDR_W(pio_pkg::WORD_ADDR_W),
            .WIDTH(32)
        ) u_ram (
            .clk(clk),
            .ce(ce),
            .we(ram_we && region_idx == 2'(r)),
            .re(ram_re && region_idx == 2'(r)),
            .addr(word_addr),
            .wdata(payload),
            .rdata(rd_word[r])
        );
    end

    // ------------------------------------------------------------
    // completion fifo
    // ------------------------------------------------------------
    stream_if #(.W(pio_pkg::FIFO_W)) cpl_in();
    stream_if #(.W(pio_pkg::FIFO_W)) cpl_out();

    stream_fifo #(
        .WIDTH(pio_pkg::FIFO_W),
        .DEPTH(pio_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .nrst(nrst),
        .ce(ce),
        .in_s(cpl_in),
        .out_s(cpl_out)
    );

    logic [pio_pkg::BEAT_CNT_W-1:0] cpl_beats;
    logic cpl_is_last;
    logic [pio_pkg::KEEP_W-1:0] beat_keep;

    assign cpl_beats = beats_for(cpl_dw_reg);
    assign cpl_is_last = (cpl_beat_reg == cpl_beats - 1'b1);

    always_comb begin
        beat_keep = '0;
        for (int k = 0; k < pio_pkg::KEEP_W; k++) begin
            beat_keep[k] = (int'(cpl_beat_reg) * pio_pkg::KEEP_W + k) < int'(cpl_dw_reg);
        end
    end

    assign cpl_in.valid = (state_reg == ST_CPL);
    assign cpl_in.data = {cpl_is_last, beat_keep,
        cpl_reg[cpl_beat_reg * pio_pkg::DATA_W +: pio_pkg::DATA_W]};
    assign cpl_out.ready = !cc_valid_reg || cc_tready;

    // ------------------------------------------------------------
    // completion descriptor assembly
    // ------------------------------------------------------------
    function automatic logic [pio_pkg::CPL_BUF_W-1:0] build_cpl(
        input logic [pio_pkg::PKT_W-1:0] p,
        input logic [10:0] dwc,
        input logic [31:0] data
    );
        build_cpl = '0;
        build_cpl[pio_pkg::CPL_W-1:0] = {
            data, 1'b0,
            p[pio_pkg::F_ATTR_LO +: 3], p[pio_pkg::F_TC_LO +: 3], 1'b0, 8'h00,
            p[pio_pkg::F_FUNC_LO +: 8], p[pio_pkg::F_TAG_LO +: 8],
            p[pio_pkg::F_REQID_LO +: 16], 2'b00, pio_pkg::CPL_STATUS_SC, dwc,
            3'b000, pio_pkg::CPL_BYTE_CNT, 6'h00, 2'b00, 1'b0,
            p[6:2], 2'b00
        };
    endfunction

    // ------------------------------------------------------------
    // request state machine
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!nrst) begin
            state_reg <= ST_RX;
            ready_reg <= 1'b0;
            beat_cnt_reg <= '0;
            pkt_reg <= '0;
            cpl_reg <= '0;
            cpl_dw_reg <= '0;
            cpl_beat_reg <= '0;
        end else if (ce) begin
            case (state_reg)
                ST_RX: begin
                    ready_reg <= 1'b1;
                    if (cq_tvalid && ready_reg) begin
                        // beats past the buffer only occur in oversize requests
                        if (int'(beat_cnt_reg) < pio_pkg::MAX_BEATS) begin
                            pkt_reg[beat_cnt_reg * pio_pkg::DATA_W +: pio_pkg::DATA_W] <= cq_tdata;
                            beat_cnt_reg <= beat_cnt_reg + 1'b1;
                        end
                        if (cq_tlast) begin
                            ready_reg <= 1'b0;
                            beat_cnt_reg <= '0;
                            state_reg <= ST_EXEC;
                        end
                    end
                end
                ST_EXEC: begin
                    if (!accept_ok) begin
                        state_reg <= ST_RX;
                    end else if (is_read) begin
                        state_reg <= ST_RDWAIT;
                    end else if (is_io_wr) begin
                        cpl_reg <= build_cpl(pkt_reg, pio_pkg::CPL_DWCNT_NODATA, 32'h0);
                        cpl_dw_reg <= pio_pkg::CPL_DW_NO_DATA;
                        cpl_beat_reg <= '0;
                        state_reg <= ST_CPL;
                    end else begin
                        state_reg <= ST_RX;
                    end
                end
                ST_RDWAIT: begin
                    cpl_reg <= build_cpl(pkt_reg, pio_pkg::CPL_DWCNT_DATA, rd_word[region_idx]);
                    cpl_dw_reg <= pio_pkg::CPL_DW_WITH_DATA;
                    cpl_beat_reg <= '0;
                    state_reg <= ST_CPL;
                end
                ST_CPL: begin
                    // a full fifo stalls here, which keeps request ready low
                    if (cpl_in.ready) begin
                        cpl_beat_reg <= cpl_beat_reg + 1'b1;
                        if (cpl_is_last) begin
                            state_reg <= ST_RX;
                        end
                    end
                end
                default: begin
                    state_reg <= ST_RX;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // trigger detection on region zero writes
    // ------------------------------------------------------------
    logic trig_base;
    assign trig_base = ram_we && (region_idx == pio_pkg::IDX_MEM32);

    always_ff @(posedge clk) begin
        if (!nrst) begin
            mrd_reg <= 1'b0;
            intx_reg <= 1'b0;
            msi_reg <= 1'b0;
            msix_reg <= 1'b0;
        end else if (ce) begin
            mrd_reg <= trig_base && byte_addr == pio_pkg::TRIG_MRD_ADDR[10:0]
                && payload == pio_pkg::TRIG_MRD_DATA;
            intx_reg <= trig_base && byte_addr == pio_pkg::TRIG_IRQ_ADDR[10:0]
                && payload == pio_pkg::TRIG_INTX_DATA;
            msi_reg <= trig_base && byte_addr == pio_pkg::TRIG_IRQ_ADDR[10:0]
                && payload == pio_pkg::TRIG_MSI_DATA;
            msix_reg <= trig_base && byte_addr == pio_pkg::TRIG_IRQ_ADDR[10:0]
                && payload == pio_pkg::TRIG_MSIX_DATA;
        end
    end

    // ------------------------------------------------------------
    // completion output register
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!nrst) begin
            cc_valid_reg <= 1'b0;
            cc_data_reg <= '0;
            cc_keep_reg <= '0;
            cc_last_reg <= 1'b0;
        end else if (ce) begin
            if (cpl_out.ready) begin
                cc_valid_reg <= cpl_out.valid;
                if (cpl_out.valid) begin
                    {cc_last_reg, cc_keep_reg, cc_data_reg} <= cpl_out.data;
                end
            end
        end
    end

    assign completer_request_ready = ready_reg;
    assign cc_tdata = cc_data_reg;
    assign cc_tkeep = cc_keep_reg;
    assign cc_tlast = cc_last_reg;
    assign cc_tvalid = cc_valid_reg;
    assign mem_read_start = mrd_reg;
    assign intx_request = intx_reg;
    assign msi_request = msi_reg;
    assign msix_request = msix_reg;
endmodule

// ==== pio_completer_target_monitor.sv ====
// port checker for the completer target, bound onto its top module
`timescale 1ns/1ps
module pio_completer_target_monitor (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    // request stream
    input wire logic [pio_pkg::DATA_W-1:0] cq_tdata,
    input wire logic cq_tvalid,
    input wire logic cq_tlast,
    input wire logic completer_request_ready,
    // completion stream
    input wire logic [pio_pkg::DATA_W-1:0] cc_tdata,
    input wire logic [pio_pkg::KEEP_W-1:0] cc_tkeep,
    input wire logic cc_tlast,
    input wire logic cc_tvalid,
    input wire logic cc_tready,
    // trigger pulses
    input wire logic mem_read_start,
    input wire logic intx_request,
    input wire logic msi_request,
    input wire logic msix_request
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    logic last_taken;
    logic hit_mrd;
    logic hit_intx;
    logic hit_msi;
    logic hit_msix;
    assign last_taken = ce && cq_tvalid && completer_request_ready && cq_tlast;
    // a write payload sits in the low word of its last beat
    always_ff @(posedge clk) begin
        hit_mrd <= last_taken && cq_tdata[31:0] == pio_pkg::TRIG_MRD_DATA;
        hit_intx <= last_taken && cq_tdata[31:0] == pio_pkg::TRIG_INTX_DATA;
        hit_msi <= last_taken && cq_tdata[31:0] == pio_pkg::TRIG_MSI_DATA;
        hit_msix <= last_taken && cq_tdata[31:0] == pio_pkg::TRIG_MSIX_DATA;
    end
    AST_READY_DROP: assert property (last_taken |=> !completer_request_ready)
        else $error("request ready stayed high after a request ended");
    AST_CPL_HOLD: assert property (cc_tvalid && !cc_tready |=> cc_tvalid && $stable(cc_tdata)
        && $stable(cc_tkeep) && $stable(cc_tlast))
        else $error("completion beat changed while stalled");
    AST_FIRST_BEAT_FULL: assert property (cc_tvalid && !cc_tlast |-> cc_tkeep == 2'h3)
        else $error("first completion beat not full");
    AST_MRD_CAUSE: assert property (mem_read_start |-> $past(hit_mrd) || $past(hit_mrd, 2))
        else $error("memory read start without its trigger write");
    AST_INTX_CAUSE: assert property (intx_request |-> $past(hit_intx) || $past(hit_intx, 2))
        else $error("legacy interrupt without its trigger write");
    AST_MSI_CAUSE: assert property (msi_request |-> $past(hit_msi) || $past(hit_msi, 2))
        else $error("msi request without its trigger write");
    AST_MSIX_CAUSE: assert property (msix_request |-> $past(hit_msix) || $past(hit_msix, 2))
        else $error("msix request without its trigger write");
    AST_TRIG_PULSE: assert property ($rose(mem_read_start) |=> !mem_read_start [*2])
        else $error("memory read start wider than one cycle");
    AST_TRIG_EXCLUSIVE: assert property ($onehot0({mem_read_start, intx_request,
        msi_request, msix_request}))
        else $error("two trigger pulses at once");
    AST_CE_FREEZE: assert property (!ce |=> $stable(completer_request_ready)
        && $stable(cc_tvalid) && $stable(mem_read_start))
        else $error("outputs moved while the clock enable was low");
endmodule

bind pio_completer_target pio_completer_target_monitor i_mon (
    .clk(clk), .nrst(nrst), .ce(ce), .cq_tdata(cq_tdata), .cq_tvalid(cq_tvalid),
    .cq_tlast(cq_tlast), .completer_request_ready(completer_request_ready),
    .cc_tdata(cc_tdata), .cc_tkeep(cc_tkeep), .cc_tlast(cc_tlast), .cc_tvalid(cc_tvalid),
    .cc_tready(cc_tready), .mem_read_start(mem_read_start), .intx_request(intx_request),
    .msi_request(msi_request), .msix_request(msix_request)
);

// ==== pio_completer_target_tb.sv ====
// self-checking bench for the completer target
`timescale 1ns/1ps
module pio_completer_target_tb;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic ce = 1'b1;
    logic hold_off = 1'b0;
    logic rnd = 1'b0;
    logic [31:0] lfsr_reg = 32'h00018545;
    logic [63:0] cq_tdata;
    logic cq_tvalid;
    logic cq_tlast;
    logic ready;
    logic [63:0] cc_tdata;
    logic [1:0] cc_tkeep;
    logic cc_tlast;
    logic cc_tvalid;
    logic cc_tready;
    logic [3:0] trig;
    logic [34:0] e;
    logic [34:0] exp_cpl[$];
    logic [3:0] exp_trig[$];
    logic [31:0] d[4];
    logic [2:0] sel_tab[4] = '{pio_pkg::SEL_MEM32, pio_pkg::SEL_MEM64, pio_pkg::SEL_EROM,
        pio_pkg::SEL_IO_DEFAULT};
    logic [31:0] trig_data[4] = '{pio_pkg::TRIG_MRD_DATA, pio_pkg::TRIG_INTX_DATA,
        pio_pkg::TRIG_MSI_DATA, pio_pkg::TRIG_MSIX_DATA};
    int hangs;
    int bad_count = 0;
    int samples_checked = 0;

    always #50 clk = ~clk;

    pio_completer_target #(.io_region_en(1'b1)) i_dut (
        .clk(clk), .nrst(nrst), .ce(ce), .cq_tdata(cq_tdata), .cq_tvalid(cq_tvalid),
        .cq_tlast(cq_tlast), .completer_request_ready(ready), .cc_tdata(cc_tdata),
        .cc_tkeep(cc_tkeep), .cc_tlast(cc_tlast), .cc_tvalid(cc_tvalid), .cc_tready(cc_tready),
        .mem_read_start(trig[3]), .intx_request(trig[2]), .msi_request(trig[1]),
        .msix_request(trig[0])
    );
    core_model i_core (
        .clk(clk), .cq_tdata(cq_tdata), .cq_tvalid(cq_tvalid), .cq_tlast(cq_tlast),
        .cq_tready(ready), .cc_tready(cc_tready), .hold_off(hold_off), .rnd(rnd), .hangs(hangs)
    );

    // ------
    // helpers
    // ------
    function automatic logic [31:0] lfsr_step(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    always @(negedge clk) begin
        lfsr_reg <= lfsr_step(lfsr_reg);
        rnd <= lfsr_reg[0];
    end
    task automatic check(input logic [63:0] seen, input logic [63:0] want);
        samples_checked++;
        if (seen !== want) begin
            bad_count++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, want);
        end
    endtask
    task automatic end_sim();
        if (bad_count == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic req(input logic [3:0] t, input logic [2:0] s, input logic [63:0] a,
        input logic [10:0] n, input logic [31:0] v);
        logic [pio_pkg::PKT_W-1:0] p;
        p = '0;
        p[63:0] = a;
        p[pio_pkg::F_DWCNT_LO+:11] = n;
        p[pio_pkg::F_REQTYPE_LO+:4] = t;
        p[pio_pkg::F_SEL_LO+:3] = s;
        p[pio_pkg::F_PAYLOAD_LO+:32] = v;
        i_core.send(p, (t == pio_pkg::REQ_MEM_RD || t == pio_pkg::REQ_IO_RD) ? 2 : (n > 2 ? 4 : 3));
    endtask

    // ------
    // result watcher
    // ------
    always @(posedge clk) begin
        if (cc_tvalid === 1'b1 && cc_tready === 1'b1 && cc_tlast === 1'b0 && exp_cpl.size() > 0)
            check({cc_tdata[45:32], cc_tdata[28:16]}, {pio_pkg::CPL_STATUS_SC,
                exp_cpl[0][34] ? pio_pkg::CPL_DWCNT_DATA : pio_pkg::CPL_DWCNT_NODATA,
                pio_pkg::CPL_BYTE_CNT});
        if (cc_tvalid === 1'b1 && cc_tready === 1'b1 && cc_tlast === 1'b1) begin
            e = (exp_cpl.size() > 0) ? exp_cpl.pop_front() : 35'h7FFFFFFFF;
            if (e[34]) check({cc_tkeep, cc_tdata[63:32]}, e[33:0]);
            else check(cc_tkeep, e[33:32]);
        end
        if (trig !== 4'h0) check(trig, (exp_trig.size() > 0) ? exp_trig.pop_front() : 4'h0);
    end

    // ------
    // main sequence
    // ------
    initial begin
        repeat (4) @(negedge clk);
        check({ready, cc_tvalid, trig}, 6'h00);
        nrst <= 1'b1;
        ce <= 1'b0;
        repeat (2) @(negedge clk);
        check(ready, 1'b0);
        ce <= 1'b1;
        @(negedge clk);
        for (int i = 0; i < 4; i++) begin
            d[i] = lfsr_reg;
            if (i == 3) exp_cpl.push_back({3'h1, 32'h0});
            req(i == 3 ? pio_pkg::REQ_IO_WR : pio_pkg::REQ_MEM_WR, sel_tab[i], 64'h40, 11'h1, d[i]);
        end
        for (int i = 0; i < 4; i++) begin
            exp_cpl.push_back({3'h7, d[i]});
            req(i == 3 ? pio_pkg::REQ_IO_RD : pio_pkg::REQ_MEM_RD, sel_tab[i], 64'h840, 11'h1, 0);
        end
        for (int i = 0; i < 4; i++) begin
            exp_trig.push_back(4'h8 >> i);
            req(pio_pkg::REQ_MEM_WR, pio_pkg::SEL_MEM32, {52'h0, i == 0 ? pio_pkg::TRIG_MRD_ADDR :
                pio_pkg::TRIG_IRQ_ADDR}, 11'h1, trig_data[i]);
        end
        req(pio_pkg::REQ_MEM_WR, pio_pkg::SEL_MEM64, {52'h0, pio_pkg::TRIG_IRQ_ADDR}, 11'h1,
            pio_pkg::TRIG_INTX_DATA);
        exp_cpl.push_back({3'h7, pio_pkg::TRIG_MSIX_DATA});
        req(pio_pkg::REQ_MEM_RD, pio_pkg::SEL_MEM32, {52'h0, pio_pkg::TRIG_IRQ_ADDR}, 11'h1, 0);
        req(pio_pkg::REQ_MEM_WR, pio_pkg::SEL_MEM32, 64'h40, 11'h3, ~d[0]);
        req(pio_pkg::REQ_MEM_RD, pio_pkg::SEL_MEM32, 64'h40, 11'h2, 0);
        req(pio_pkg::REQ_MEM_RD, 3'h5, 64'h40, 11'h1, 0);
        // completions stay parked so the fifo fills and stops requests
        hold_off <= 1'b1;
        for (int i = 0; i < 9; i++) begin
            exp_cpl.push_back({3'h7, d[0]});
            req(pio_pkg::REQ_MEM_RD, pio_pkg::SEL_MEM32, 64'h40, 11'h1, 0);
        end
        repeat (8) @(negedge clk);
        check(ready, 1'b0);
        hold_off <= 1'b0;
        for (int w = 0; w < 3000 && exp_cpl.size() + exp_trig.size() > 0; w++) @(negedge clk);
        check(exp_cpl.size() + exp_trig.size(), 0);
        check(hangs, 0);
        end_sim();
    end
endmodule

// ==== pio_pkg.sv ====
// constants shared by the completer target and its helpers
package pio_pkg;

    // ------------------------------------------------------------
    // stream geometry
    // ------------------------------------------------------------
    localparam int DATA_W = 64;
    localparam int KEEP_W = DATA_W / 32;
    localparam int PKT_W = 256;
    localparam int MAX_BEATS = PKT_W / DATA_W;
    localparam int BEAT_CNT_W = 3;
    localparam int CPL_W = 128;
    localparam int CPL_BUF_W = (DATA_W > CPL_W) ? DATA_W : CPL_W;
    localparam int FIFO_W = DATA_W + KEEP_W + 1;
    localparam int FIFO_DEPTH = 16;

    // ------------------------------------------------------------
    // target regions
    // ------------------------------------------------------------
    localparam int REGION_COUNT = 4;
    localparam int REGION_BYTES = 2048;
    localparam int WORD_ADDR_W = 9;
    localparam logic [2:0] SEL_MEM32 = 3'h0;
    localparam logic [2:0] SEL_MEM64 = 3'h1;
    localparam logic [2:0] SEL_EROM = 3'h6;
    localparam logic [2:0] SEL_IO_DEFAULT = 3'h2;
    localparam logic [1:0] IDX_MEM32 = 2'h0;
    localparam logic [1:0] IDX_MEM64 = 2'h1;
    localparam logic [1:0] IDX_EROM = 2'h2;
    localparam logic [1:0] IDX_IO = 2'h3;

    // ------------------------------------------------------------
    // request descriptor fields (bit positions)
    // ------------------------------------------------------------
    localparam int F_ADDR_LO = 2;
    localparam int F_DWCNT_LO = 64;
    localparam int F_REQTYPE_LO = 75;
    localparam int F_REQID_LO = 80;
    localparam int F_TAG_LO = 96;
    localparam int F_FUNC_LO = 104;
    localparam int F_SEL_LO = 112;
    localparam int F_TC_LO = 121;
    localparam int F_ATTR_LO = 124;
    localparam int F_PAYLOAD_LO = 128;
    localparam logic [3:0] REQ_MEM_RD = 4'h0;
    localparam logic [3:0] REQ_MEM_WR = 4'h1;
    localparam logic [3:0] REQ_IO_RD = 4'h2;
    localparam logic [3:0] REQ_IO_WR = 4'h3;

    // ------------------------------------------------------------
    // completion fields
    // ------------------------------------------------------------
    localparam logic [2:0] CPL_STATUS_SC = 3'h0;
    localparam logic [12:0] CPL_BYTE_CNT = 13'h0004;
    localparam logic [10:0] CPL_DWCNT_DATA = 11'h001;
    localparam logic [10:0] CPL_DWCNT_NODATA = 11'h000;
    localparam logic [2:0] CPL_DW_WITH_DATA = 3'h4;
    localparam logic [2:0] CPL_DW_NO_DATA = 3'h3;

    // ------------------------------------------------------------
    // trigger writes into region zero
    // ------------------------------------------------------------
    // trigger addresses are wider than a 2 KB region; the top bit aliases away
    localparam logic [11:0] TRIG_MRD_ADDR = 12'hEA8;
    localparam logic [31:0] TRIG_MRD_DATA = 32'hAAAABBBB;
    localparam logic [11:0] TRIG_IRQ_ADDR = 12'hEEC;
    localparam logic [31:0] TRIG_INTX_DATA = 32'hCCCCDDDD;
    localparam logic [31:0] TRIG_MSI_DATA = 32'hEEEEFFFF;
    localparam logic [31:0] TRIG_MSIX_DATA = 32'hDEADBEEF;

endpackage

// ==== region_ram.sv ====
// one target region: word ram with registered read port
`timescale 1ns/1ps
module region_ram #(
    parameter int ADDR_W = 9,
    parameter int WIDTH = 32
) (
    // clock
    input wire logic clk,
    input wire logic ce,
    // access port
    input wire logic we,
    input wire logic re,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [WIDTH-1:0] wdata,
    output logic [WIDTH-1:0] rdata
);
    logic [WIDTH-1:0] mem [2**ADDR_W];

    always_ff @(posedge clk) begin
        if (ce && we) begin
            mem[addr] <= wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (ce && re) begin
            rdata <= mem[addr];
        end
    end
endmodule

// ==== stream_fifo.sv ====
// synchronous word fifo with valid/ready on both sides
`timescale 1ns/1ps
module stream_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    // streams
    stream_if.snk in_s,
    stream_if.src out_s
);
    localparam int PTR_W = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wr_ptr_reg;
    logic [PTR_W-1:0] rd_ptr_reg;
    logic [PTR_W:0] count_reg;
    logic push;
    logic pop;

    assign in_s.ready = (count_reg != DEPTH[PTR_W:0]);
    assign out_s.valid = (count_reg != '0);
    assign out_s.data = mem[rd_ptr_reg];
    assign push = ce && in_s.valid && in_s.ready;
    assign pop = ce && out_s.valid && out_s.ready;

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_s.data;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            if (push && !pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (pop && !push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end
endmodule

// ==== stream_if.sv ====
// valid/ready word stream between the target's own modules
`timescale 1ns/1ps
interface stream_if #(parameter int W = 8);
    logic [W-1:0] data;
    logic valid;
    logic ready;
    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);
endinterface
